// file: design/touch_link_pkg.sv
// Constants and types shared by the touch-sensor serial target link
package touch_link_pkg;
  // Timing
  localparam int CLK_MHZ = 20;
  localparam int STRETCH_MAX_US = 40;
  localparam int STRETCH_CYC = STRETCH_MAX_US * CLK_MHZ;
  localparam logic [9:0] STRETCH_LAST = 10'(STRETCH_CYC - 1);
  // Frame layout, receive buffer and address strap
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_WR, ST_PUSH, ST_LOAD, ST_RD, ST_RACK, ST_IGNORE
  } link_state_t;

  // Received byte handed to the user side
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } rx_word_t;
endpackage : touch_link_pkg

// file: design/touch_link_target.sv
// Serial target link of the touch-sensor device: framing, addressing, acknowledge and stretching
// How it works
// - Data is sampled only on clock rises and the device changes its data output only while the clock is low.
// - Start is a falling data line and stop a rising data line while the clock is high, and both are detected.
// - The device only pulls a line low or releases it, never driving it high.
// - The first byte after start is seven address bits, a direction bit, then an acknowledge slot.
// - A direction bit of one makes a read that returns data, zero makes a write that accepts data.
// - On its own address the device holds the data line low through the ninth clock.
// - Each data byte is eight bits and one acknowledge slot driven by the receiver.
// - A released data line in the ninth clock is a refusal, and the transmitter stops sending.
// - A transaction is start, address, one or more data bytes, then stop.
// - The device may hold the clock low between bytes, at most 40 us.
`timescale 1ns/1ns
`default_nettype none
module touch_link_target (
  // System clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Address strap
  input wire logic [6:0] addr_strap,
  // Bus pins, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Received bytes
  output touch_link_pkg::rx_word_t rx_word,
  output logic rx_valid,
  input wire logic rx_ready,
  // Bytes to send
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // Status
  output logic busy
);
  import touch_link_pkg::*;

  // Link domain: capture data on each bus clock rise, flag by toggle
  logic cap_bit;
  logic cap_tog;
  always_ff @(posedge scl_in or negedge nrst) begin
    if (!nrst) begin
      cap_bit <= 1'b0;
      cap_tog <= 1'b0;
    end else begin
      cap_bit <= sda_in;
      cap_tog <= ~cap_tog;
    end
  end

  // Synchronisers into the system domain
  logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q, tog_m, tog_s, tog_q;
  logic [6:0] addr_m, addr_s, own_addr;
  logic [1:0] addr_wait;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_q <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_q <= 1'b1;
      tog_m <= 1'b0;
      tog_s <= 1'b0;
      tog_q <= 1'b0;
      addr_m <= ADDR_RESET;
      addr_s <= ADDR_RESET;
      own_addr <= ADDR_RESET;
      addr_wait <= 2'h0;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_q <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_q <= sda_s;
      tog_m <= cap_tog;
      tog_s <= tog_m;
      tog_q <= tog_s;
      addr_m <= addr_strap;
      addr_s <= addr_m;
      if (addr_wait != 2'h3) begin
        addr_wait <= addr_wait + 2'h1;
      end
      // Strap caught once both sync stages hold it
      if (addr_wait == STRAP_SETTLE) begin
        own_addr <= addr_s;
      end
    end
  end

  logic start_ev, stop_ev, rise_ev, fall_ev;
  assign start_ev = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_ev = scl_s & scl_q & ~sda_q & sda_s;
  assign rise_ev = tog_s ^ tog_q;
  assign fall_ev = scl_q & ~scl_s;

  // Two-entry receive buffer
  rx_word_t buf_mem [2];
  logic wr_ptr, rd_ptr;
  logic [1:0] buf_cnt;
  logic buf_in_ready, buf_push, buf_pop;
  rx_word_t buf_in;
  rx_word_t next_mem0, next_mem1;
  logic next_wr_ptr, next_rd_ptr;
  logic [1:0] next_buf_cnt;

  assign buf_in_ready = buf_cnt != BUF_DEPTH;
  assign rx_valid = buf_cnt != 2'h0;
  assign buf_pop = rx_valid & rx_ready;
  assign rx_word = buf_mem[rd_ptr];

  always_comb begin
    next_mem0 = buf_mem[0];
    next_mem1 = buf_mem[1];
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_buf_cnt = buf_cnt;
    if (buf_push) begin
      if (wr_ptr) begin
        next_mem1 = buf_in;
      end else begin
        next_mem0 = buf_in;
      end
      next_wr_ptr = ~wr_ptr;
    end
    if (buf_pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    if (buf_push && !buf_pop) begin
      next_buf_cnt = buf_cnt + 2'h1;
    end else if (buf_pop && !buf_push) begin
      next_buf_cnt = buf_cnt - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      buf_mem[0] <= next_mem0;
      buf_mem[1] <= next_mem1;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      buf_cnt <= next_buf_cnt;
    end
  end

  // Protocol engine
  link_state_t state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift, next_shift;
  logic is_read, next_is_read;
  logic ack_drive, next_ack_drive;
  logic first_byte, next_first_byte;
  logic host_nack, next_host_nack;
  logic [9:0] stretch_cnt, next_stretch_cnt;
  logic next_sda_oe, next_scl_oe;
  logic stretch_out;

  assign stretch_out = stretch_cnt == STRETCH_LAST;
  assign buf_in = '{first: first_byte, data: shift};

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_is_read = is_read;
    next_ack_drive = ack_drive;
    next_first_byte = first_byte;
    next_host_nack = host_nack;
    next_stretch_cnt = 10'h000;
    buf_push = 1'b0;
    tx_ready = 1'b0;
    if (start_ev) begin
      next_state = ST_ADDR;
      next_bit_cnt = 4'h0;
    end else if (stop_ev) begin
      next_state = ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE, ST_IGNORE: begin
          next_state = state;
        end
        ST_ADDR, ST_WR: begin
          if (rise_ev && bit_cnt != BITS_PER_BYTE) begin
            next_shift = {shift[6:0], cap_bit};
            next_bit_cnt = bit_cnt + 4'h1;
          end
          if (fall_ev && bit_cnt == BITS_PER_BYTE) begin
            if (state == ST_WR) begin
              next_state = ST_PUSH;
            end else if (shift[7:1] == own_addr) begin
              next_is_read = shift[0];
              next_ack_drive = 1'b1;
              next_first_byte = 1'b1;
              next_state = ST_ACK;
            end else begin
              next_state = ST_IGNORE;
            end
          end
        end
        ST_PUSH: begin
          next_stretch_cnt = stretch_cnt + 10'h001;
          if (buf_in_ready) begin
            buf_push = 1'b1;
            next_first_byte = 1'b0;
            next_ack_drive = 1'b1;
            next_state = ST_ACK;
          end else if (stretch_out) begin
            next_ack_drive = 1'b0;
            next_state = ST_ACK;
          end
        end
        ST_ACK: begin
          if (fall_ev) begin
            next_bit_cnt = 4'h0;
            if (!ack_drive) begin
              next_state = ST_IGNORE;
            end else if (is_read) begin
              next_state = ST_LOAD;
            end else begin
              next_state = ST_WR;
            end
          end
        end
        ST_LOAD: begin
          next_stretch_cnt = stretch_cnt + 10'h001;
          tx_ready = 1'b1;
          if (tx_valid) begin
            next_shift = tx_data;
            next_state = ST_RD;
          end else if (stretch_out) begin
            next_shift = IDLE_BYTE;
            next_state = ST_RD;
          end
        end
        ST_RD: begin
          if (fall_ev) begin
            next_shift = {shift[6:0], 1'b1};
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == LAST_TX_BIT) begin
              next_state = ST_RACK;
            end
          end
        end
        ST_RACK: begin
          if (rise_ev) begin
            next_host_nack = cap_bit;
          end
          if (fall_ev) begin
            next_bit_cnt = 4'h0;
            next_state = host_nack ? ST_IGNORE : ST_LOAD;
          end
        end
      endcase
    end
    // Open-drain drives: only pulls low, changed while clock is low
    next_sda_oe = 1'b0;
    if (next_state == ST_ACK) begin
      next_sda_oe = next_ack_drive;
    end else if (next_state == ST_RD) begin
      next_sda_oe = ~next_shift[7];
    end
    // Data settles one cycle before the clock is let go
    next_scl_oe = (next_state == ST_PUSH) || (next_state == ST_LOAD) ||
      (((state == ST_PUSH) || (state == ST_LOAD)) && next_sda_oe);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      is_read <= 1'b0;
      ack_drive <= 1'b0;
      first_byte <= 1'b0;
      host_nack <= 1'b0;
      stretch_cnt <= 10'h000;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      is_read <= next_is_read;
      ack_drive <= next_ack_drive;
      first_byte <= next_first_byte;
      host_nack <= next_host_nack;
      stretch_cnt <= next_stretch_cnt;
      sda_oe <= next_sda_oe;
      scl_oe <= next_scl_oe;
    end
  end

  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign busy = state != ST_IDLE;
endmodule : touch_link_target
`default_nettype wire

// file: dv/touch_link_target_assertions.sv
// Port checks of the serial target link
`timescale 1ns/1ns
`default_nettype none
module touch_link_target_checker
  import touch_link_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus
  input wire logic scl_in,
  input wire logic scl_oe,
  input wire logic scl_out,
  input wire logic sda_in,
  input wire logic sda_oe,
  input wire logic sda_out,
  // User side
  input wire touch_link_pkg::rx_word_t rx_word,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic busy
);
  logic [9:0] held;
  logic [9:0] next_held;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Cycles of one stretch
  always_comb next_held = scl_oe ? held + 10'h1 : 10'h0;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) held <= 10'h0;
    else held <= next_held;
  end
  a_pins_low: assert property (!scl_out && !sda_out) else $error("pin high");
  a_stretch_max: assert property (held <= STRETCH_CYC) else $error("long stretch");
  a_rx_held: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_word)) else $error("rx lost");
  a_idle_quiet: assert property (!busy |-> !sda_oe && !scl_oe) else $error("idle drive");
  a_start_seen: assert property ($fell(sda_in) && scl_in && !busy |-> ##[1:5] busy) else $error("no start");
  a_stop_seen: assert property ($rose(sda_in) && scl_in && busy |-> ##[1:5] !busy) else $error("no stop");
  a_sda_clk_low: assert property ($changed(sda_oe) |-> !$past(scl_in)) else $error("sda moved");
  a_tx_taken: assert property (tx_valid && tx_ready |=> !tx_ready) else $error("tx kept");
endmodule : touch_link_target_checker
bind touch_link_target touch_link_target_checker chk (.clk, .nrst, .scl_in, .scl_oe, .scl_out, .sda_in, .sda_oe,
  .sda_out, .rx_word, .rx_valid, .rx_ready, .tx_valid, .tx_ready, .busy);
`default_nettype wire

// file: dv/host_model.sv
// Bus controller model for the host side of the link
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // Timing clock
  input wire logic clk,
  // Wired bus levels
  input wire logic scl_in,
  input wire logic sda_in,
  // Releases, high means let go
  output var logic host_scl = 1'b1,
  output var logic host_sda = 1'b1
);
  task automatic hw(input int n);
    repeat (n) @(negedge clk);
  endtask : hw
  task automatic start;
    host_sda = 1'b0;
    hw(8);
    host_scl = 1'b0;
    hw(4);
  endtask : start
  task automatic stop;
    host_sda = 1'b0;
    hw(4);
    host_scl = 1'b1;
    hw(8);
    host_sda = 1'b1;
    hw(8);
  endtask : stop
  // Nine clocks, each bit set while the clock is low
  task automatic xfer(input logic [8:0] out, output logic [8:0] seen);
    for (int i = 8; i >= 0; i--) begin
      host_sda = out[i];
      hw(4);
      host_scl = 1'b1;
      for (int n = 0; n < 900 && !scl_in; n++) hw(1);
      hw(4);
      seen[i] = sda_in;
      hw(4);
      host_scl = 1'b0;
      hw(4);
    end
    host_sda = 1'b1;
  endtask : xfer
endmodule : host_model
`default_nettype wire

// file: dv/test_touch_link_target.sv
// Bench of the serial target link against a bus controller model
`timescale 1ns/1ns
`default_nettype none
module test_touch_link_target;
  import touch_link_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic rx_ready = 1'b0;
  logic tx_valid = 1'b0;
  logic host_scl, host_sda, scl_oe, sda_oe, rx_valid, tx_ready, busy;
  logic [8:0] r;
  rx_word_t rx_word;
  int failures = 0;
  int check_count = 0;
  // Address, data, acknowledge expected
  logic [16:0] rows [3] = '{{8'h54, 8'h5a, 1'b1}, {8'h54, 8'ha5, 1'b1}, {8'h88, 8'h5a, 1'b0}};
  wire logic scl_in = ~scl_oe & host_scl;
  wire logic sda_in = ~sda_oe & host_sda;
  always #25 clk = ~clk;
  touch_link_target uut (.clk, .nrst, .addr_strap(7'h2a), .scl_in, .scl_out(), .scl_oe, .sda_in, .sda_out(),
    .sda_oe, .rx_word, .rx_valid, .rx_ready, .tx_data(8'h3c), .tx_valid, .tx_ready, .busy);
  host_model host (.clk, .scl_in, .sda_in, .host_scl, .host_sda);
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic pop(input logic [8:0] exp);
    check("rx word", {rx_valid, rx_word}, {1'b1, exp});
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
  endtask : pop
  task automatic report_and_stop;
    $display("Checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (8) @(negedge clk);
    foreach (rows[i]) begin
      host.start();
      host.xfer({rows[i][16:9], 1'b1}, r);
      check("addr ack", 10'(r[0]), 10'(!rows[i][0]));
      host.xfer({rows[i][8:1], 1'b1}, r);
      check("data ack", 10'(r[0]), 10'(!rows[i][0]));
      host.stop();
      check("busy", 10'(busy), 10'h0);
      if (rows[i][0]) begin
        pop({1'b1, rows[i][8:1]});
      end else begin
        check("rx none", 10'(rx_valid), 10'h0);
      end
      $display("Row %0d done", i);
    end
    // Receiver stalls: third byte stretched, then refused
    host.start();
    host.xfer(9'h0a9, r);
    for (int i = 0; i < 3; i++) begin
      host.xfer({8'h10 + 8'(i), 1'b1}, r);
      check("burst ack", 10'(r[0]), 10'(i == 2));
    end
    host.stop();
    pop(9'h110);
    pop(9'h011);
    $display("Burst done");
    tx_valid = 1'b1;
    host.start();
    host.xfer(9'h0ab, r);
    check("read addr ack", 10'(r[0]), 10'h0);
    host.xfer(9'h1fe, r);
    check("read", 10'(r), 10'h078);
    host.xfer(9'h1ff, r);
    check("read", 10'(r), 10'h079);
    host.stop();
    tx_valid = 1'b0;
    host.start();
    host.xfer(9'h0ab, r);
    host.xfer(9'h1ff, r);
    host.stop();
    check("read empty", 10'(r), 10'h1ff);
    $display("Read done");
    host.start();
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    check("reset", {5'h0, busy, rx_valid, sda_oe, scl_oe, tx_ready}, 10'h0);
    nrst = 1'b1;
    host.stop();
    host.start();
    host.xfer(9'h0a9, r);
    check("reset addr ack", 10'(r[0]), 10'h0);
    host.xfer(9'h0ef, r);
    check("reset data ack", 10'(r[0]), 10'h0);
    host.stop();
    pop(9'h177);
    $display("Reset done");
    report_and_stop();
  end
endmodule : test_touch_link_target
`default_nettype wire
